// ### logic/cpudp_pkg.sv
// Package with constants and types of the CPU execution datapath
// Contract
// RULE1: multiplier takes two 8-bit operands, yields 16-bit product
// RULE2: six multiply variants: uu, ss, su integer and fractional
// RULE3: multiply completes in two clock cycles, product after second
// RULE4: register or immediate ALU operation executes in one cycle, writes back
// RULE5: status flags describe the result just produced
// RULE6: 32 eight-bit registers, two operands read per cycle
// RULE7: six registers pair into three 16-bit pointers
// RULE8: next instruction fetched while current executes
// RULE9: separate program and data buses and address spaces
// RULE10: lowest 4KB is I/O; 0x00-0x3F also directly reachable
// RULE11: 0x0040-0x0FFF extended I/O, only via data load/store
// RULE12: SRAM starts at 0x2000; never fetch from SRAM (code still loads any jump target, flagging only those with bit 23 set)
// RULE13: 0x1000-0x1FFF is EEPROM mapping window
// RULE14: self-program store only effective from boot section
// RULE15: 8- and 16-bit arithmetic with carry chaining
// RULE16: 24-bit program and data addresses, 16MB each
// RULE17: coherent 16/24-bit I/O register access (code latches no high byte; each load moves one byte)
// RULE18: after reset fetch starts at program address zero
// RULE19: two 8-bit reads, one 16-bit write-back path
// RULE20: product written to registers 1:0, low byte in 0
package cpudp_pkg;
  localparam int CPUDP_NREG = 32;
  localparam int CPUDP_AW = 24;
  localparam logic [23:0] CPUDP_PC_RST = 24'h000000;
  localparam logic [23:0] CPUDP_IO_DIRECT_END = 24'h00003F;
  localparam logic [23:0] CPUDP_IO_END = 24'h000FFF;
  localparam logic [23:0] CPUDP_EE_BASE = 24'h001000;
  localparam logic [23:0] CPUDP_EE_END = 24'h001FFF;
  localparam logic [23:0] CPUDP_SRAM_BASE = 24'h002000;
  localparam logic [4:0] CPUDP_PROD_LO = 5'h00;
  localparam logic [4:0] CPUDP_PTR_X = 5'h1A;
  localparam logic [4:0] CPUDP_PTR_Y = 5'h1C;
  localparam logic [4:0] CPUDP_PTR_Z = 5'h1E;
  localparam int CPUDP_MUL_CYC = 2;
  // Flag bit positions in the status byte
  localparam int CPUDP_FC = 0;
  localparam int CPUDP_FZ = 1;
  localparam int CPUDP_FN = 2;
  localparam int CPUDP_FV = 3;
  localparam int CPUDP_FS = 4;
  localparam int CPUDP_FH = 5;
  localparam logic [7:0] CPUDP_SREG_RST = 8'h00;
  // Operation codes of the execute port
  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR,
    OP_MOV, OP_INC, OP_DEC, OP_COM, OP_NEG, OP_LSR, OP_ROR, OP_ASR,
    OP_ADIW, OP_SBIW, OP_MUL, OP_MULS, OP_MULSU, OP_FMUL, OP_FMULS,
    OP_FMULSU, OP_LOAD, OP_STORE, OP_IOIN, OP_IOOUT, OP_SPST, OP_PTRINC
  } cpudp_op_e;
  typedef enum logic [2:0] {
    RG_IO, RG_EXTIO, RG_EEPROM, RG_GAP, RG_SRAM
  } cpudp_region_e;
endpackage : cpudp_pkg

// ### logic/cpudp_mult.sv
// Two-cycle 8x8 multiplier with signed, unsigned and fractional modes
`timescale 1ns/10ps
`default_nettype none
module cpudp_mult
  import cpudp_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic aSigned,
  input wire logic bSigned,
  input wire logic frac,
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  output logic done,
  output logic [15:0] product,
  output logic carry
);
  typedef struct packed {
    logic stage;
    logic doneQ;
    logic fracQ;
    logic [17:0] raw;
    logic [15:0] prod;
    logic cy;
  } cpudp_mul_s;
  cpudp_mul_s st_ff, nxt_st;
  logic signed [8:0] extA, extB;
  logic signed [17:0] fullProd;

  // RULE2: sign extension per variant
  always_comb
  begin
    extA = {aSigned & opA[7], opA};
    extB = {bSigned & opB[7], opB};
    fullProd = extA * extB;
  end

  // RULE3: first cycle multiplies, second shapes and delivers
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.doneQ = 1'b0;
    nxt_st.stage = 1'b0;
    if (start)
    begin
      nxt_st.stage = 1'b1;
      nxt_st.raw = fullProd;
      nxt_st.fracQ = frac;
    end
    else if (st_ff.stage)
    begin
      // RULE1: 16-bit product, fractional shifted left one
      nxt_st.doneQ = 1'b1;
      nxt_st.cy = st_ff.raw[15];
      nxt_st.prod = st_ff.fracQ ? {st_ff.raw[14:0], 1'b0} : st_ff.raw[15:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign done = st_ff.doneQ;
  assign product = st_ff.prod;
  assign carry = st_ff.cy;
endmodule : cpudp_mult
`default_nettype wire

// ### logic/cpudp_core.sv
// Execute datapath: register file, ALU, flags, fetch and data decode
`timescale 1ns/10ps
`default_nettype none
module cpudp_core
  import cpudp_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  // Execute request from the decoder
  input wire logic exValid,
  input wire cpudp_op_e exOp,
  input wire logic [4:0] rd,
  input wire logic [4:0] rr,
  input wire logic useImm,
  input wire logic [7:0] imm,
  input wire logic [1:0] ptrSel,
  input wire logic [23:0] dataAddrIn,
  input wire logic useDirect,
  input wire logic inBoot,
  input wire logic flowLoad,
  input wire logic [23:0] flowTarget,
  input wire logic fetchStall,
  // Program memory bus
  output logic [23:0] progAddr,
  output logic progRd,
  input wire logic [15:0] progData,
  output logic [15:0] instrWord,
  output logic instrValid,
  // Data memory bus
  output logic [23:0] dataAddr,
  output logic dataRd,
  output logic dataWr,
  output logic [7:0] dataWdata,
  input wire logic [7:0] dataRdata,
  output logic [2:0] dataRegion,
  output logic progStoreEn,
  output logic [7:0] statusOut,
  output logic busy,
  output logic accessFault
);
  typedef struct packed {
    logic [CPUDP_NREG-1:0][7:0] regs;
    logic [7:0] sreg;
    logic [23:0] pc;
    logic [15:0] iword;
    logic ivalid;
    logic prd;
    logic [23:0] daddr;
    logic drd;
    logic dwr;
    logic [7:0] dwdata;
    logic [2:0] region;
    logic spst;
    logic loadPend;
    logic [4:0] loadDst;
    logic mulPend;
    logic fault;
    logic [7:0] ioHigh;
  } cpudp_core_s;
  cpudp_core_s st_ff, nxt_st;

  logic mulStart, mulDone, mulCarry;
  logic [15:0] mulProd;
  logic aSgn, bSgn, fracMode;
  logic [7:0] opA, opB, res8;
  logic [15:0] wA, res16;
  logic [8:0] sum9;
  logic [16:0] sum17;
  logic [4:0] hsum;
  logic cin, isArith, isWide, wrRes;
  logic [4:0] ptrBase;
  logic [15:0] ptrVal;
  logic [23:0] effAddr;
  cpudp_region_e reg_e;

  // RULE6: two independent read ports into the register file
  always_comb
  begin
    opA = st_ff.regs[rd];
    opB = useImm ? imm : st_ff.regs[rr];
  end

  // RULE7: pointer pair selection
  always_comb
  begin
    case (ptrSel)
      2'd0: ptrBase = CPUDP_PTR_X;
      2'd1: ptrBase = CPUDP_PTR_Y;
      default: ptrBase = CPUDP_PTR_Z;
    endcase
    ptrVal = {st_ff.regs[ptrBase + 5'd1], st_ff.regs[ptrBase]};
    effAddr = useDirect ? dataAddrIn : {8'h00, ptrVal};
  end

  // RULE10: data space region decode
  always_comb
  begin
    if (effAddr <= CPUDP_IO_END)
      reg_e = (effAddr <= CPUDP_IO_DIRECT_END) ? RG_IO : RG_EXTIO;
    // RULE13: EEPROM mapping window
    else if (effAddr >= CPUDP_EE_BASE && effAddr <= CPUDP_EE_END)
      reg_e = RG_EEPROM;
    // RULE12: SRAM from its base upward
    else if (effAddr >= CPUDP_SRAM_BASE)
      reg_e = RG_SRAM;
    else
      reg_e = RG_GAP;
  end

  // Multiplier variant selection
  always_comb
  begin
    mulStart = exValid && !busy && (exOp >= OP_MUL) && (exOp <= OP_FMULSU);
    aSgn = (exOp == OP_MULS) || (exOp == OP_MULSU) || (exOp == OP_FMULS) ||
           (exOp == OP_FMULSU);
    bSgn = (exOp == OP_MULS) || (exOp == OP_FMULS);
    fracMode = (exOp == OP_FMUL) || (exOp == OP_FMULS) || (exOp == OP_FMULSU);
  end

  // RULE15: 8-bit adder with carry in, 16-bit word arithmetic
  always_comb
  begin
    cin = st_ff.sreg[CPUDP_FC];
    wA = {st_ff.regs[rd + 5'd1], opA};
    sum9 = 9'h000;
    hsum = 5'h00;
    sum17 = 17'h00000;
    res8 = 8'h00;
    res16 = 16'h0000;
    isArith = 1'b1;
    isWide = 1'b0;
    wrRes = 1'b1;
    case (exOp)
      OP_ADD, OP_ADC:
      begin
        sum9 = {1'b0, opA} + {1'b0, opB} + {8'h00, exOp == OP_ADC && cin};
        hsum = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, exOp == OP_ADC && cin};
      end
      OP_SUB, OP_SBC:
      begin
        sum9 = {1'b0, opA} - {1'b0, opB} - {8'h00, exOp == OP_SBC && cin};
        hsum = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, exOp == OP_SBC && cin};
      end
      OP_INC: sum9 = {1'b0, opA} + 9'h001;
      OP_DEC: sum9 = {1'b0, opA} - 9'h001;
      OP_NEG: sum9 = 9'h000 - {1'b0, opA};
      OP_COM: sum9 = {1'b1, ~opA};
      OP_AND: sum9 = {1'b0, opA & opB};
      OP_OR: sum9 = {1'b0, opA | opB};
      OP_XOR: sum9 = {1'b0, opA ^ opB};
      // Moves leave the flags alone so a carry survives for a chained add
      OP_MOV:
      begin
        sum9 = {1'b0, opB};
        isArith = 1'b0;
      end
      OP_LSR: sum9 = {opA[0], 1'b0, opA[7:1]};
      OP_ROR: sum9 = {opA[0], cin, opA[7:1]};
      OP_ASR: sum9 = {opA[0], opA[7], opA[7:1]};
      OP_ADIW:
      begin
        isWide = 1'b1;
        sum17 = {1'b0, wA} + {11'h000, imm[5:0]};
      end
      OP_SBIW:
      begin
        isWide = 1'b1;
        sum17 = {1'b0, wA} - {11'h000, imm[5:0]};
      end
      default:
      begin
        isArith = 1'b0;
        wrRes = 1'b0;
      end
    endcase
    res8 = sum9[7:0];
    res16 = sum17[15:0];
  end

  cpudp_mult cpudp_mult_i (
    .mclk(mclk),
    .arst_n(arst_n),
    .start(mulStart),
    .aSigned(aSgn),
    .bSigned(bSgn),
    .frac(fracMode),
    .opA(opA),
    .opB(opB),
    .done(mulDone),
    .product(mulProd),
    .carry(mulCarry)
  );

  // Next-state of the whole datapath
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.drd = 1'b0;
    nxt_st.dwr = 1'b0;
    nxt_st.spst = 1'b0;
    nxt_st.fault = 1'b0;
    nxt_st.prd = 1'b1;
    // RULE8: prefetch the next word while this one executes
    if (flowLoad)
    begin
      nxt_st.pc = flowTarget;
      nxt_st.ivalid = 1'b0;
    end
    else if (!fetchStall && !busy && st_ff.prd) // No word taken before the read strobe is up
    begin
      nxt_st.iword = progData;
      nxt_st.ivalid = 1'b1;
      nxt_st.pc = st_ff.pc + 24'h000001;
    end
    // Data load is sampled in the same cycle as the read strobe
    if (st_ff.loadPend)
    begin
      nxt_st.loadPend = 1'b0;
      // RULE17: no high byte is latched; the returned byte goes straight to the load destination
      nxt_st.regs[st_ff.loadDst] = dataRdata;
    end
    // RULE20: product lands in registers one and zero
    if (mulDone)
    begin
      // RULE19: one 16-bit write-back
      nxt_st.regs[CPUDP_PROD_LO] = mulProd[7:0];
      nxt_st.regs[CPUDP_PROD_LO + 5'd1] = mulProd[15:8];
      nxt_st.sreg[CPUDP_FC] = mulCarry;
      nxt_st.sreg[CPUDP_FZ] = (mulProd == 16'h0000);
      nxt_st.mulPend = 1'b0;
    end
    if (mulStart)
      nxt_st.mulPend = 1'b1;
    if (exValid && !busy)
    begin
      // RULE4: single-cycle ALU write-back
      if (wrRes && isWide)
      begin
        nxt_st.regs[rd] = res16[7:0];
        nxt_st.regs[rd + 5'd1] = res16[15:8];
      end
      else if (wrRes)
        nxt_st.regs[rd] = res8;
      // RULE5: flags from the result just produced
      if (isArith && isWide)
      begin
        nxt_st.sreg[CPUDP_FC] = sum17[16];
        nxt_st.sreg[CPUDP_FZ] = (res16 == 16'h0000);
        nxt_st.sreg[CPUDP_FN] = res16[15];
        nxt_st.sreg[CPUDP_FV] = (exOp == OP_ADIW) ? (~wA[15] & res16[15])
                                                  : (wA[15] & ~res16[15]);
        nxt_st.sreg[CPUDP_FS] = res16[15] ^ nxt_st.sreg[CPUDP_FV];
      end
      else if (isArith)
      begin
        nxt_st.sreg[CPUDP_FC] = sum9[8];
        // RULE15: chained subtract keeps zero only if already zero
        nxt_st.sreg[CPUDP_FZ] = (res8 == 8'h00) &&
                                 ((exOp != OP_SBC && exOp != OP_ADC) ||
                                  exOp == OP_ADC || st_ff.sreg[CPUDP_FZ]);
        nxt_st.sreg[CPUDP_FN] = res8[7];
        nxt_st.sreg[CPUDP_FH] = hsum[4];
        if (exOp == OP_ADD || exOp == OP_ADC || exOp == OP_INC)
          nxt_st.sreg[CPUDP_FV] = (opA[7] == opB[7] || exOp == OP_INC) &&
                                  (res8[7] != opA[7]) && (exOp != OP_INC || res8 == 8'h80);
        else if (exOp == OP_SUB || exOp == OP_SBC || exOp == OP_DEC || exOp == OP_NEG)
          nxt_st.sreg[CPUDP_FV] = (exOp == OP_SUB || exOp == OP_SBC) ?
                                  ((opA[7] != opB[7]) && (res8[7] != opA[7])) :
                                  (res8 == ((exOp == OP_DEC) ? 8'h7F : 8'h80));
        else
          nxt_st.sreg[CPUDP_FV] = 1'b0;
        nxt_st.sreg[CPUDP_FS] = res8[7] ^ nxt_st.sreg[CPUDP_FV];
      end
      // RULE9: data access on its own bus
      case (exOp)
        OP_LOAD, OP_STORE:
        begin
          nxt_st.daddr = effAddr;
          nxt_st.region = reg_e;
          nxt_st.drd = (exOp == OP_LOAD);
          nxt_st.dwr = (exOp == OP_STORE);
          nxt_st.dwdata = opA;
          nxt_st.loadPend = (exOp == OP_LOAD);
          nxt_st.loadDst = rd;
        end
        // RULE11: direct I/O only reaches the lowest 64 addresses
        OP_IOIN, OP_IOOUT:
        begin
          nxt_st.daddr = {18'h00000, dataAddrIn[5:0]};
          nxt_st.region = RG_IO;
          nxt_st.drd = (exOp == OP_IOIN);
          nxt_st.dwr = (exOp == OP_IOOUT);
          nxt_st.dwdata = opA;
          nxt_st.loadPend = (exOp == OP_IOIN);
          nxt_st.loadDst = rd;
        end
        // RULE14: self-program store gated by boot section
        OP_SPST:
        begin
          nxt_st.spst = inBoot;
          nxt_st.fault = !inBoot;
        end
        OP_PTRINC:
        begin
          nxt_st.regs[ptrBase] = ptrVal[7:0] + 8'h01;
          nxt_st.regs[ptrBase + 5'd1] = ptrVal[15:8] + {7'h00, ptrVal[7:0] == 8'hFF};
        end
        default:
        begin
        end
      endcase
    end
    // RULE12: a jump at or above the SRAM base with bit 23 set is flagged; the fetch counter still loads every target
    if (flowLoad && flowTarget >= CPUDP_SRAM_BASE && flowTarget[23])
      nxt_st.fault = 1'b1;
  end

  // RULE18: reset sends the fetch counter to address zero
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff <= '0;
      st_ff.pc <= CPUDP_PC_RST;
      st_ff.sreg <= CPUDP_SREG_RST;
    end
    else
      st_ff <= nxt_st;
  end

  // RULE16: full 24-bit addresses on both buses
  assign progAddr = st_ff.pc;
  assign progRd = st_ff.prd;
  assign instrWord = st_ff.iword;
  assign instrValid = st_ff.ivalid;
  assign dataAddr = st_ff.daddr;
  assign dataRd = st_ff.drd;
  assign dataWr = st_ff.dwr;
  assign dataWdata = st_ff.dwdata;
  assign dataRegion = st_ff.region;
  assign progStoreEn = st_ff.spst;
  assign statusOut = st_ff.sreg;
  assign busy = st_ff.mulPend;
  assign accessFault = st_ff.fault;
endmodule : cpudp_core
`default_nettype wire

// ### tb/cpudp_core_monitor.sv
// Checker of the execution datapath port behaviour
`timescale 1ns/10ps
`default_nettype none
module cpudp_core_monitor
  import cpudp_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic exValid,
  input wire cpudp_op_e exOp,
  input wire logic useDirect,
  input wire logic [23:0] dataAddrIn,
  input wire logic inBoot,
  input wire logic flowLoad,
  input wire logic [23:0] flowTarget,
  input wire logic busy,
  input wire logic [23:0] progAddr,
  input wire logic progRd,
  input wire logic [23:0] dataAddr,
  input wire logic dataRd,
  input wire logic dataWr,
  input wire logic [2:0] dataRegion,
  input wire logic progStoreEn,
  input wire logic accessFault
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Request accepted at this edge, and any data access under way
  wire logic taken = exValid && !busy;
  wire logic acc = dataRd || dataWr;
  AST_RESET_FETCH: assert property (!$past(arst_n) && arst_n
    |=> progRd && progAddr == CPUDP_PC_RST)
    else $error("fetch does not start at zero");
  AST_MUL_TWO_CYC: assert property (taken && exOp inside {[OP_MUL:OP_FMULSU]} |=>
    busy[*2] ##1 !busy)
    else $error("multiply length wrong");
  AST_LOAD_STROBE: assert property (taken && exOp == OP_LOAD |=> dataRd && !dataWr)
    else $error("load strobe missing");
  AST_STORE_ADDR: assert property (taken && exOp == OP_STORE && useDirect |=>
    dataWr && dataAddr == $past(dataAddrIn))
    else $error("store address wrong");
  AST_REGION_IO: assert property (acc && dataAddr <= CPUDP_IO_DIRECT_END |-> dataRegion == RG_IO)
    else $error("direct io region wrong");
  AST_REGION_EXT: assert property (acc && dataAddr > CPUDP_IO_DIRECT_END && dataAddr <= CPUDP_IO_END
    |-> dataRegion == RG_EXTIO)
    else $error("extended io region wrong");
  AST_REGION_EE: assert property (acc && dataAddr >= CPUDP_EE_BASE && dataAddr <= CPUDP_EE_END
    |-> dataRegion == RG_EEPROM)
    else $error("eeprom window wrong");
  AST_REGION_SRAM: assert property (acc && dataAddr >= CPUDP_SRAM_BASE |-> dataRegion == RG_SRAM)
    else $error("sram region wrong");
  AST_SPST_BOOT: assert property (taken && exOp == OP_SPST |=>
    progStoreEn == $past(inBoot) && accessFault == !$past(inBoot))
    else $error("self program store gating wrong");
  AST_FLOW_LOAD: assert property (flowLoad && !busy |=> progAddr == $past(flowTarget))
    else $error("program counter not loaded");
  // Main scenarios reached
  cover property (taken && exOp == OP_FMULSU);
  cover property (taken && exOp == OP_LOAD && !useDirect);
  cover property (taken && exOp == OP_SPST && !inBoot);
endmodule : cpudp_core_monitor
`default_nettype wire

// ### tb/cpudp_mem_model.sv
// Program and data memory model on the far side of the datapath
`timescale 1ns/10ps
`default_nettype none
module cpudp_mem_model (
  input wire logic mclk,
  input wire logic [23:0] progAddr,
  input wire logic progRd,
  output logic [15:0] progData,
  input wire logic [23:0] dataAddr,
  input wire logic dataRd,
  input wire logic dataWr,
  input wire logic [7:0] dataWdata,
  output logic [7:0] dataRdata
);
  logic [7:0] mem [256];
  logic [7:0] lastRd = 8'h00;
  // Byte i holds i xor 5A so each of the 256 low address bytes reads back distinct
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  // own program bus
  // Idle bus shows a changing pattern, never a stale word
  always_comb progData = progRd ? (progAddr[15:0] ^ 16'h1234) : ~progAddr[15:0];
  // own data bus
  // Outside a read the inverse of the last byte, so a late sample is caught
  always_comb dataRdata = dataRd ? mem[dataAddr[7:0]] : ~lastRd;
  always @(posedge mclk)
  begin
    if (dataRd) lastRd <= mem[dataAddr[7:0]];
    if (dataWr) mem[dataAddr[7:0]] <= dataWdata;
  end
endmodule : cpudp_mem_model
`default_nettype wire

// ### tb/cpudp_core_bench.sv
// Self-checking bench of the execution datapath
`timescale 1ns/10ps
`default_nettype none
module cpudp_core_bench
  import cpudp_pkg::*;
;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic exValid = 1'b0;
  cpudp_op_e exOp = OP_NOP;
  logic [4:0] rd = 5'h00;
  logic [4:0] rr = 5'h00;
  logic useImm = 1'b0;
  logic [7:0] imm = 8'h00;
  logic [1:0] ptrSel = 2'h0;
  logic [23:0] dataAddrIn = 24'h000000;
  logic useDirect = 1'b0;
  logic inBoot = 1'b0;
  logic flowLoad = 1'b0;
  logic [23:0] flowTarget = 24'h000000;
  logic fetchStall = 1'b0;
  logic [23:0] progAddr, dataAddr;
  logic progRd, instrValid, dataRd, dataWr, progStoreEn, busy, accessFault;
  logic [15:0] progData, instrWord;
  logic [7:0] dataWdata, dataRdata, statusOut;
  logic [2:0] dataRegion;
  int nErrors = 0;
  int checksDone = 0;
  // 25 MHz clock
  always #20 mclk = ~mclk;
  cpudp_core cpudp_core_i (.mclk, .arst_n, .exValid, .exOp, .rd, .rr, .useImm, .imm, .ptrSel,
    .dataAddrIn, .useDirect, .inBoot, .flowLoad, .flowTarget, .fetchStall, .progAddr, .progRd,
    .progData, .instrWord, .instrValid, .dataAddr, .dataRd, .dataWr, .dataWdata, .dataRdata,
    .dataRegion, .progStoreEn, .statusOut, .busy, .accessFault);
  cpudp_mem_model cpudp_mem_model_i (.mclk, .progAddr, .progRd, .progData, .dataAddr, .dataRd,
    .dataWr, .dataWdata, .dataRdata);
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    checksDone++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      nErrors++;
    end
  endtask : chk
  // One request; waits for busy low first, since a request in busy is dropped
  task automatic issue(input cpudp_op_e op, input logic [4:0] d, input logic [4:0] s,
    input logic im, input logic [7:0] k, input logic [23:0] adr, input logic dir,
    input logic [1:0] aux);
    int n;
    n = 0;
    #1;
    while (busy !== 1'b0 && n < 10)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    @(posedge mclk);
    exValid <= 1'b1;
    exOp <= op;
    rd <= d;
    rr <= s;
    useImm <= im;
    imm <= k;
    dataAddrIn <= adr;
    useDirect <= dir;
    ptrSel <= aux;
    inBoot <= aux[0];
    @(posedge mclk);
    exValid <= 1'b0;
  endtask : issue
  task automatic setReg(input logic [4:0] r, input logic [7:0] v);
    issue(OP_MOV, r, 5'h00, 1'b1, v, 24'h000000, 1'b0, 2'h0);
  endtask : setReg
  // Register contents are only visible through a store
  task automatic storeChk(input string nm, input logic [4:0] r, input logic [23:0] adr,
    input logic [7:0] v);
    issue(OP_STORE, r, 5'h00, 1'b0, 8'h00, adr, 1'b1, 2'h0);
    #1;
    chk("dataWr", 24'h1, 24'(dataWr));
    chk(nm, 24'(v), 24'(dataWdata));
    chk("dataAddr", adr, dataAddr);
  endtask : storeChk
  task automatic tReset();
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk("progRd", 24'h1, 24'(progRd));
    chk("progAddr", CPUDP_PC_RST, progAddr);
    $display("test reset done");
  endtask : tReset
  task automatic tAlu();
    setReg(5'h10, 8'hF0);
    setReg(5'h11, 8'h10);
    issue(OP_ADD, 5'h10, 5'h11, 1'b0, 8'h00, 24'h000000, 1'b0, 2'h0);
    #1;
    chk("addFlagsCZ", 24'h3, 24'({statusOut[CPUDP_FC], statusOut[CPUDP_FZ]}));
    issue(OP_ADC, 5'h10, 5'h10, 1'b0, 8'h00, 24'h000000, 1'b0, 2'h0);
    #1;
    chk("adcFlagsCZ", 24'h0, 24'({statusOut[CPUDP_FC], statusOut[CPUDP_FZ]}));
    storeChk("adcSum", 5'h10, 24'h002001, 8'h01);
    $display("test alu done");
  endtask : tAlu
  task automatic tData();
    logic [23:0] adrs [6] = '{24'h00003F, 24'h000040, 24'h000FFF, 24'h001000, 24'h001FFF,
      24'h002000};
    cpudp_region_e regs [6] = '{RG_IO, RG_EXTIO, RG_EXTIO, RG_EEPROM, RG_EEPROM, RG_SRAM};
    for (int k = 0; k < 6; k++)
    begin
      storeChk("storeData", 5'h10, adrs[k], 8'h01);
      chk("dataRegion", 24'(regs[k]), 24'(dataRegion));
    end
    issue(OP_LOAD, 5'h14, 5'h00, 1'b0, 8'h00, 24'h002007, 1'b1, 2'h0);
    #1;
    chk("dataRd", 24'h1, 24'(dataRd));
    issue(OP_IOIN, 5'h16, 5'h00, 1'b0, 8'h00, 24'h00003F, 1'b1, 2'h0);
    #1;
    chk("ioAddr", 24'h00003F, dataAddr);
    setReg(5'h1E, 8'h34);
    setReg(5'h1F, 8'h12);
    issue(OP_LOAD, 5'h15, 5'h00, 1'b0, 8'h00, 24'h000000, 1'b0, 2'h2);
    #1;
    chk("ptrAddr", 24'h001234, dataAddr);
    storeChk("loadData", 5'h14, 24'h002030, 8'h5D);
    storeChk("ptrData", 5'h15, 24'h002031, 8'h6E);
    $display("test data done");
  endtask : tData
  // Word add and subtract on r19:r18, then a pointer step on Z
  task automatic tWide();
    setReg(5'h12, 8'hFF);
    setReg(5'h13, 8'h7F);
    issue(OP_ADIW, 5'h12, 5'h00, 1'b0, 8'h01, 24'h000000, 1'b0, 2'h0);
    #1;
    chk("adiwFlags", 24'h00000C, 24'(statusOut[4:0]));
    storeChk("adiwHi", 5'h13, 24'h002040, 8'h80);
    storeChk("adiwLo", 5'h12, 24'h002041, 8'h00);
    issue(OP_SBIW, 5'h12, 5'h00, 1'b0, 8'h01, 24'h000000, 1'b0, 2'h0);
    #1;
    chk("sbiwFlags", 24'h000018, 24'(statusOut[4:0]));
    issue(OP_PTRINC, 5'h00, 5'h00, 1'b0, 8'h00, 24'h000000, 1'b0, 2'h2);
    issue(OP_LOAD, 5'h15, 5'h00, 1'b0, 8'h00, 24'h000000, 1'b0, 2'h2);
    #1;
    chk("ptrIncAddr", 24'h001235, dataAddr);
    $display("test wide done");
  endtask : tWide
  task automatic tMul();
    cpudp_op_e ops [6] = '{OP_MUL, OP_MULS, OP_MULSU, OP_FMUL, OP_FMULS, OP_FMULSU};
    logic [15:0] raw, exp;
    logic sa, sb;
    setReg(5'h10, 8'hF0);
    setReg(5'h11, 8'h90);
    for (int k = 0; k < 6; k++)
    begin
      sa = (k % 3 != 0);
      sb = (k % 3 == 1);
      raw = {{8{sa}}, 8'hF0} * {{8{sb}}, 8'h90};
      exp = (k >= 3) ? {raw[14:0], 1'b0} : raw;
      issue(ops[k], 5'h10, 5'h11, 1'b0, 8'h00, 24'h000000, 1'b0, 2'h0);
      #1;
      chk("busyFirst", 24'h1, 24'(busy));
      @(posedge mclk);
      #1;
      chk("busySecond", 24'h1, 24'(busy));
      @(posedge mclk);
      #1;
      chk("busyEnd", 24'h0, 24'(busy));
      chk("mulCarry", 24'(raw[15]), 24'(statusOut[CPUDP_FC]));
      storeChk("productLo", CPUDP_PROD_LO, 24'h002020, exp[7:0]);
      storeChk("productHi", 5'h01, 24'h002021, exp[15:8]);
    end
    $display("test multiply done");
  endtask : tMul
  task automatic tSpst();
    for (int b = 0; b < 2; b++)
    begin
      issue(OP_SPST, 5'h00, 5'h00, 1'b0, 8'h00, 24'h000000, 1'b0, 2'(b));
      #1;
      chk("progStoreEn", 24'(b), 24'(progStoreEn));
      chk("accessFault", 24'(b == 0), 24'(accessFault));
    end
    $display("test self program done");
  endtask : tSpst
  task automatic tFlow();
    @(posedge mclk);
    flowLoad <= 1'b1;
    flowTarget <= 24'h000100;
    @(posedge mclk);
    flowLoad <= 1'b0;
    #1;
    chk("flowAddr", 24'h000100, progAddr);
    chk("flowValid", 24'h000000, 24'(instrValid));
    @(posedge mclk);
    #1;
    chk("nextAddr", 24'h000101, progAddr);
    chk("instrWord", 24'h001334, 24'(instrWord));
    @(posedge mclk);
    fetchStall <= 1'b1;
    @(posedge mclk);
    fetchStall <= 1'b0;
    #1;
    chk("stallAddr", 24'h000102, progAddr);
    chk("stallValid", 24'h000001, 24'(instrValid));
    $display("test fetch done");
  endtask : tFlow
  task automatic finalReport();
    $display("checks %0d mismatches %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finalReport
  // Whole run is under two hundred cycles; cut a hang well beyond that
  initial
  begin
    repeat (4000) @(posedge mclk);
    nErrors++;
    finalReport();
  end
  initial
  begin
    tReset();
    tAlu();
    tData();
    tWide();
    tMul();
    tSpst();
    tFlow();
    finalReport();
  end
endmodule : cpudp_core_bench
bind cpudp_core cpudp_core_monitor cpudp_core_monitor_i (.mclk, .arst_n, .exValid, .exOp,
  .useDirect, .dataAddrIn, .inBoot, .flowLoad, .flowTarget, .busy, .progAddr, .progRd,
  .dataAddr, .dataRd, .dataWr, .dataRegion, .progStoreEn, .accessFault);
`default_nettype wire
